// >>> hw/atpwm_pkg.sv
// Shared constants for the async timer and up/down PWM corner logic
package atpwm_pkg;
	localparam int CLK_MHZ = 250;
	// Crystal-driven timer
	localparam int BYTE_W = 8;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] BYTE_JUNK = 8'hA5; // Pattern standing for undefined contents
	// Oscillator settle time, one second
	localparam int SETTLE_MS = 1000;
	localparam longint SETTLE_CYC = longint'(SETTLE_MS) * 1000 * CLK_MHZ;
	// Wide timer
	localparam int WIDE_W = 16;
	localparam logic [15:0] WIDE_RST = 16'h0000;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIRECT = 3'h1;
	// Power states
	typedef enum logic [1:0] {ATPWM_RUN, ATPWM_SAVE, ATPWM_DOWN} atpwm_pwr_e;
endpackage

// >>> hw/atpwm_sync.sv
// Two-flop synchroniser with edge pulse for the crystal input
module atpwm_sync (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic din,
	output logic rise
);
	logic s1;
	logic s2;
	logic s3;
	logic next_s1;
	logic next_s2;
	logic next_s3;
	// Next values; s1 feeds s2, s2 feeds s3
	always_comb begin
		next_s1 = din;
		next_s2 = s1;
		next_s3 = s2;
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= next_s1;
			s2 <= next_s2;
			s3 <= next_s3;
		end
	end
	assign rise = s2 & ~s3;
endmodule

// >>> hw/atpwm_top.sv
// Async byte timer with sleep behaviour and 16-bit up/down PWM
// Functional notes
// R1 - With async clocking selected the crystal oscillator runs in every state except power-down.
// R2 - Software waits at least one second after power-up or power-down exit before using the async timer.
// R3 - Leaving power-down leaves every async timer register undefined, crystal or external clock alike.
// R4 - With async select at 0, waking from power-save leaves the async timer registers undefined.
// R5 - Compare equal to top with clock select 001 gives no PWM pulse at all.
// R6 - Compare equal to top with a prescaled clock drives the PWM output active at top.
// R7 - In that prescaled case the down match waits for the next top, giving a one-period pulse.
module atpwm_top #(
	parameter longint SETTLE_CYCLES = atpwm_pkg::SETTLE_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [1:0] power_state,
	input wire logic async_clock_select,
	input wire logic timer_crystal_input,
	input wire logic byte_load,
	input wire logic [7:0] byte_load_value,
	input wire logic [2:0] wide_timer_clock_select,
	input wire logic [15:0] wide_top,
	input wire logic [15:0] wide_compare,
	input wire logic wide_prescale_tick,
	output logic osc_running,
	output logic osc_settled,
	output logic [7:0] async_byte_count,
	output logic [15:0] wide_count,
	output logic pwm_out
);
	atpwm_pkg::atpwm_pwr_e pwr;
	atpwm_pkg::atpwm_pwr_e prev_pwr;
	logic xtal_rise;
	logic [39:0] settle_cnt;
	logic [39:0] next_settle_cnt;
	logic [7:0] next_byte;
	logic next_osc_settled;
	logic wake_down;
	logic wake_save;

	always_comb begin
		case (power_state)
			2'h1: pwr = atpwm_pkg::ATPWM_SAVE;
			2'h2: pwr = atpwm_pkg::ATPWM_DOWN;
			default: pwr = atpwm_pkg::ATPWM_RUN;
		endcase
	end

	// Crystal input crosses in through two flops
	atpwm_sync u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.din(timer_crystal_input),
		.rise(xtal_rise)
	);

	// Oscillator runs only with async clocking selected, and then stops only in power-down
	assign osc_running = async_clock_select & (pwr != atpwm_pkg::ATPWM_DOWN); // [R1]
	assign wake_down = (prev_pwr == atpwm_pkg::ATPWM_DOWN) && (pwr != atpwm_pkg::ATPWM_DOWN);
	assign wake_save = (prev_pwr == atpwm_pkg::ATPWM_SAVE) && (pwr == atpwm_pkg::ATPWM_RUN);

	// Byte timer and settle counter next values
	always_comb begin
		next_byte = async_byte_count;
		next_settle_cnt = settle_cnt;
		next_osc_settled = osc_settled;
		if (!osc_running) begin
			next_settle_cnt = '0;
			next_osc_settled = 1'b0;
		end else if (!osc_settled) begin
			// Status only; waiting on it is software's job [R2]
			next_settle_cnt = settle_cnt + 40'h1;
			next_osc_settled = (settle_cnt + 40'h1) >= 40'(SETTLE_CYCLES);
		end
		if (wake_down) begin
			next_byte = atpwm_pkg::BYTE_JUNK; // [R3]
		end else if (wake_save && !async_clock_select) begin
			next_byte = atpwm_pkg::BYTE_JUNK; // [R4]
		end else if (byte_load) begin
			next_byte = byte_load_value;
		end else if (osc_running && xtal_rise) begin
			next_byte = async_byte_count + 8'h01;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			async_byte_count <= atpwm_pkg::BYTE_RST;
			settle_cnt <= '0;
			osc_settled <= 1'b0;
			prev_pwr <= atpwm_pkg::ATPWM_RUN;
		end else begin
			async_byte_count <= next_byte;
			settle_cnt <= next_settle_cnt;
			osc_settled <= next_osc_settled;
			prev_pwr <= pwr;
		end
	end

	// Up/down PWM
	logic dir_down;
	logic next_dir_down;
	logic [15:0] next_wide;
	logic next_pwm;
	logic arm_down;
	logic next_arm_down;
	logic step;
	logic at_top;
	logic eq_top;
	logic direct;

	assign direct = (wide_timer_clock_select == atpwm_pkg::CS_DIRECT);
	assign step = direct | ((wide_timer_clock_select != atpwm_pkg::CS_STOP) & wide_prescale_tick);
	assign at_top = (wide_count == wide_top);
	assign eq_top = (wide_compare == wide_top);

	always_comb begin
		next_wide = wide_count;
		next_dir_down = dir_down;
		next_pwm = pwm_out;
		next_arm_down = arm_down;
		if (step) begin
			if (!dir_down) begin
				if (wide_count + 16'h1 >= wide_top) begin
					next_wide = wide_top;
					next_dir_down = 1'b1;
				end else begin
					next_wide = wide_count + 16'h1;
				end
			end else if (wide_count <= 16'h1) begin
				next_wide = 16'h0;
				next_dir_down = 1'b0;
			end else begin
				next_wide = wide_count - 16'h1;
			end
			if (eq_top) begin
				if (direct) begin
					next_pwm = 1'b0; // Up and down matches coincide [R5]
					next_arm_down = 1'b0;
				end else if (next_wide == wide_top) begin
					// Entering top: first arrival sets, the following one clears
					if (arm_down) begin
						next_pwm = 1'b0; // [R7]
						next_arm_down = 1'b0;
					end else begin
						next_pwm = 1'b1; // [R6]
						next_arm_down = 1'b1;
					end
				end
			end else begin
				next_arm_down = 1'b0;
				if (next_wide == wide_compare) begin
					next_pwm = ~next_dir_down;
				end
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wide_count <= atpwm_pkg::WIDE_RST;
			dir_down <= 1'b0;
			pwm_out <= 1'b0;
			arm_down <= 1'b0;
		end else begin
			wide_count <= next_wide;
			dir_down <= next_dir_down;
			pwm_out <= next_pwm;
			arm_down <= next_arm_down;
		end
	end

	// Steps spent high, so a pulse can be measured against top even with a gappy prescaler
	logic [16:0] hi_steps;
	logic [16:0] next_hi_steps;
	always_comb begin
		next_hi_steps = 17'h0;
		if (pwm_out) begin
			next_hi_steps = step ? hi_steps + 17'h1 : hi_steps;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hi_steps <= 17'h0;
		end else begin
			hi_steps <= next_hi_steps;
		end
	end

	// Checks
	chk_xtal_count: assert property (@(posedge clk_sys) disable iff (srst) // [R1]
		(osc_running && xtal_rise && !byte_load && !wake_down && !wake_save)
		|=> (async_byte_count == $past(async_byte_count) + 8'h01)) else $error("crystal edge not counted");
	chk_xtal_refused: assert property (@(posedge clk_sys) disable iff (srst) // [R1]
		(!osc_running && !byte_load && !wake_down && !wake_save) |=> $stable(async_byte_count))
		else $error("count moved while stopped");
	chk_settle_time: assert property (@(posedge clk_sys) disable iff (srst) // [R2]
		$rose(osc_settled) |-> (settle_cnt == 40'(SETTLE_CYCLES))) else $error("settle flag at wrong count");
	chk_down_wait: assert property (@(posedge clk_sys) disable iff (srst) // [R7]
		(pwm_out && eq_top && !direct && !(step && next_wide == wide_top)) |=> pwm_out)
		else $error("down match cleared output");
	chk_period_steps: assert property (@(posedge clk_sys) disable iff (srst) // [R7]
		($fell(pwm_out) && eq_top && !direct && $stable(wide_top) && wide_top > 16'h1)
		|-> (hi_steps == {wide_top, 1'b0})) else $error("pulse not one period");
	chk_osc_down_stop: assert property (@(posedge clk_sys) disable iff (srst)
		(pwr == atpwm_pkg::ATPWM_DOWN) |-> !osc_running) else $error("osc runs in power-down"); // [R1]
	chk_osc_run_on: assert property (@(posedge clk_sys) disable iff (srst)
		(async_clock_select && pwr != atpwm_pkg::ATPWM_DOWN) |-> osc_running) else $error("osc stopped"); // [R1]
	chk_wake_down_junk: assert property (@(posedge clk_sys) disable iff (srst)
		wake_down |=> (async_byte_count == atpwm_pkg::BYTE_JUNK)) else $error("no junk after down"); // [R3]
	chk_wake_save_junk: assert property (@(posedge clk_sys) disable iff (srst)
		(wake_save && !async_clock_select && !wake_down) |=> (async_byte_count == atpwm_pkg::BYTE_JUNK))
		else $error("no junk after save"); // [R4]
	chk_settle_clear: assert property (@(posedge clk_sys) disable iff (srst)
		!osc_running |=> !osc_settled) else $error("settled while stopped"); // [R2]
	chk_direct_no_pulse: assert property (@(posedge clk_sys) disable iff (srst)
		(step && direct && eq_top) |=> !pwm_out) else $error("pulse at direct clock"); // [R5]
	chk_top_set: assert property (@(posedge clk_sys) disable iff (srst)
		(step && !direct && eq_top && !arm_down && next_wide == wide_top) |=> pwm_out)
		else $error("no set at top"); // [R6]
	chk_hold_period: assert property (@(posedge clk_sys) disable iff (srst)
		($rose(pwm_out) && eq_top && !direct && $stable(wide_compare) && $stable(wide_top) && wide_top > 16'h1)
		|=> pwm_out) else $error("pulse ended early"); // [R7]
endmodule

// >>> verif/atpwm_top_bench.sv
// Self-checking bench for the async byte timer and up/down PWM corners
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module atpwm_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SETTLE = 20; // Short settle count keeps the run brief
	logic clk_sys = 0, srst = 1, async_clock_select = 0, timer_crystal_input = 0, byte_load = 0;
	logic [1:0] power_state = 0;
	logic [7:0] byte_load_value = 0;
	logic [2:0] wide_timer_clock_select = 0;
	logic [15:0] wide_top = 0, wide_compare = 0;
	logic wide_prescale_tick = 0, osc_running, osc_settled, pwm_out;
	logic [7:0] async_byte_count;
	logic [15:0] wide_count;
	int miscompares = 0, compares = 0, cycles = 0;
	logic [7:0] v;
	logic [15:0] t;
	int n;
	atpwm_top #(.SETTLE_CYCLES(SETTLE)) i_atpwm_top (.clk_sys(clk_sys), .srst(srst), .power_state(power_state),
		.async_clock_select(async_clock_select), .timer_crystal_input(timer_crystal_input), .byte_load(byte_load),
		.byte_load_value(byte_load_value), .wide_timer_clock_select(wide_timer_clock_select), .wide_top(wide_top),
		.wide_compare(wide_compare), .wide_prescale_tick(wide_prescale_tick), .osc_running(osc_running),
		.osc_settled(osc_settled), .async_byte_count(async_byte_count), .wide_count(wide_count), .pwm_out(pwm_out));
	// 250 MHz system clock
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	// Hang guard, well above the expected run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	function automatic logic exp_osc(input logic sel, input logic [1:0] ps);
		return sel && ps != 2'h2;
	endfunction
	task automatic step(input int k);
		repeat (k) @(negedge clk_sys);
	endtask
	task automatic print_verdict;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic load(input logic [7:0] val);
		byte_load = 1;
		byte_load_value = val;
		step(1);
		byte_load = 0;
		`CHK(async_byte_count, val)
	endtask
	// Sleep in the given state, then back to run
	task automatic sleep_wake(input logic [1:0] ps, input logic sel);
		async_clock_select = sel;
		power_state = ps;
		step(3);
		power_state = 2'h0;
		step(1);
	endtask
	task automatic pwm_reset(input logic [2:0] cs);
		srst = 1;
		step(2);
		srst = 0;
		wide_timer_clock_select = cs;
		wide_top = t;
		wide_compare = t;
	endtask
	task automatic xtal_pulses(input int k);
		repeat (k) begin
			timer_crystal_input = 1;
			step(4);
			timer_crystal_input = 0;
			step(4);
		end
		step(4);
	endtask
	// Steps while pwm_out equals lvl; counts prescale ticks when rnd, else cycles
	task automatic hold_count(input logic lvl, input int lim, input bit rnd);
		n = 0;
		for (int k = 0; k < lim && pwm_out === lvl; k++) begin
			if (rnd)
				wide_prescale_tick = 1'($urandom);
			n += rnd ? int'(wide_prescale_tick) : 1;
			step(1);
		end
	endtask
	initial begin
		void'($urandom(32'hE05C));
		wide_prescale_tick = 1; // Prescaled steps every cycle
		step(8);
		srst = 0;
		`CHK(async_byte_count, 8'h00)
		`CHK(pwm_out, 1'b0)
		for (int i = 0; i < 8; i++) begin
			async_clock_select = i[2];
			power_state = i[1:0];
			step(1);
			`CHK(osc_running, exp_osc(i[2], i[1:0]))
		end
		power_state = 0;
		step(1);
		// Wake from power-down, crystal and external clock alike
		for (int s = 0; s < 2; s++) begin
			load(8'($urandom));
			sleep_wake(2'h2, s[0]);
			`CHK(async_byte_count, atpwm_pkg::BYTE_JUNK)
		end
		`CHK(osc_settled, 1'b0)
		step(SETTLE - 2);
		`CHK(osc_settled, 1'b0)
		step(1);
		`CHK(osc_settled, 1'b1)
		v = 8'($urandom);
		load(v);
		sleep_wake(2'h1, 1'b1);
		`CHK(async_byte_count, v)
		sleep_wake(2'h1, 1'b0);
		`CHK(async_byte_count, atpwm_pkg::BYTE_JUNK)
		async_clock_select = 1;
		v = 8'($urandom);
		load(v);
		n = $urandom_range(6, 1);
		xtal_pulses(n);
		`CHK(async_byte_count, 8'(v + n))
		// Crystal edges are ignored while the oscillator is stopped
		async_clock_select = 0;
		xtal_pulses(2);
		`CHK(async_byte_count, 8'(v + n))
		// Compare at top without prescaling never pulses
		t = 16'($urandom_range(40, 4));
		pwm_reset(atpwm_pkg::CS_DIRECT);
		n = 0;
		repeat (8 * t) begin
			step(1);
			n += int'(pwm_out === 1'b1);
		end
		`CHK(n, 0)
		// Compare below top: set on the up match, clear on the down match
		v = 8'($urandom_range(t - 1, 1));
		wide_compare = 16'(v);
		hold_count(1'b0, 4 * t, 1'b0);
		hold_count(1'b1, 4 * t, 1'b0);
		`CHK(n, 2 * (int'(t) - int'(v)))
		// Every prescaled select with random ticks: one full period high from top
		for (int c = 2; c < 8; c++) begin
			t = 16'($urandom_range(40, 4));
			pwm_reset(3'(c));
			hold_count(1'b0, 16 * t, 1'b1);
			`CHK(wide_count, t)
			hold_count(1'b1, 32 * t, 1'b1);
			`CHK(n, 2 * int'(t))
		end
		wide_timer_clock_select = atpwm_pkg::CS_STOP;
		step(1);
		t = wide_count;
		step(5);
		`CHK(wide_count, t)
		print_verdict();
	end
endmodule
